// File: inc/svc_seq_pkg.sv
package svc_seq_pkg;
    localparam int PULSE_GAP = 1;
    localparam int NUM_PULSES = 5;
    localparam int BYTE_ADDR_LOW_W = 3;
    localparam int BYTE_ADDR_HIGH_W = 16;
    localparam int COUNT_W = 16;
    localparam int SUBCH_W = 8;
    localparam int DATA_W = 32;
    localparam int FLAGS_W = 16;
    localparam int SIL_BIT = 6;
    localparam int STAT_LO = 8;
    localparam int STAT_HI = 14;
    localparam int FIFO_DEPTH = 16;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    typedef enum {
        PH_IDLE, PH_CONNECT, PH_ADDRESS, PH_INTAKE, PH_XFER,
        PH_CARRY, PH_FETCH1, PH_FETCH2, PH_LOAD, PH_TERM
    } phase_e;
endpackage

// File: src/pulse_train.sv
`timescale 1ns/1ps
// Delay-line model: a start pulse yields T0..T4 one cycle apart
module pulse_train #(
    parameter int PULSES = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Control
    input wire logic start,
    output logic busy,
    output logic [PULSES-1:0] tap
);
    logic [PULSES-1:0] shift_reg;

    // --------------------------------------------------------
    // Pulse shifter
    // --------------------------------------------------------
    // Restart is refused while running, like a real delay line
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shift_reg <= '0;
        end else if (start && !busy) begin
            shift_reg <= {{(PULSES-1){1'b0}}, 1'b1};
        end else begin
            shift_reg <= {shift_reg[PULSES-2:0], 1'b0};
        end
    end

    assign tap = shift_reg;
    assign busy = |shift_reg;
endmodule

// File: src/byte_fifo.sv
`timescale 1ns/1ps
// Simple synchronous FIFO with valid/ready on both sides
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWr;
    logic doRd;

    assign inReady = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    assign outData = mem[rdPtr_reg];

    // --------------------------------------------------------
    // Storage and pointers
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers wrap at a power-of-two depth
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule

// File: src/service_cycle_sequencer.sv
`timescale 1ns/1ps
module service_cycle_sequencer
    import svc_seq_pkg::*;
#(
    parameter int COUNT_BITS = svc_seq_pkg::COUNT_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Controller interface
    input wire logic serviceCall,
    output logic ackServiceCallIndicator,
    output logic functionStrobe,
    input wire logic functionStrobeLeadingResponse,
    input wire logic [svc_seq_pkg::SUBCH_W-1:0] functionResponseLines,
    input wire logic requestStrobe,
    output logic requestStrobeAck,
    input wire logic dataOrderLine,
    input wire logic inputOutputLine,
    input wire logic deviceEndData,
    input wire logic [7:0] statusByte,
    output logic endServiceOut,
    output logic endDataOut,
    // Outgoing byte stream
    output logic byteValid,
    input wire logic byteReady,
    output logic [7:0] byteData,
    // Memory port
    output logic memReq,
    output logic [18:0] memAddr,
    input wire logic memAck,
    input wire logic [svc_seq_pkg::DATA_W-1:0] memData,
    // Subchannel context, loaded and returned by the outside store
    output logic [svc_seq_pkg::SUBCH_W-1:0] subchannelAddr,
    input wire logic [18:0] byteAddrIn,
    input wire logic [COUNT_BITS-1:0] byteCountIn,
    input wire logic dataChainIn,
    input wire logic errorHaltEnableIn,
    input wire logic incorrectLengthIn,
    input wire logic [svc_seq_pkg::FLAGS_W-1:0] flagStatusIn,
    output logic [svc_seq_pkg::FLAGS_W-1:0] workingStatus,
    output logic errorReport,
    output logic [7:0] terminalOrder,
    output logic cycleDone
);
    phase_e phase_reg;
    logic [NUM_PULSES-1:0] tap;
    logic trainBusy;
    logic trainStart;
    logic functionIndicator_reg, fsPending_reg, ackOne_reg, ackTwo_reg;
    logic permit_reg, firstPass_reg, orderFlag_reg, endData_reg;
    logic endService_reg, boundary_reg, termOrder_reg, zeroCount_reg;
    logic errorHalt_reg, carryIn_reg, branch_reg, memPend_reg;
    logic [18:0] byteAddr_reg;
    logic [COUNT_BITS-1:0] byteCount_reg;
    logic [DATA_W-1:0] holding_reg;
    logic [7:0] order_reg;
    logic [FLAGS_W-1:0] work_reg;
    logic fifoInReady;
    logic pushByte;
    logic lowCarry;
    logic startCond;

    // --------------------------------------------------------
    // Phase timing
    // --------------------------------------------------------
    // pulse train per phase
    pulse_train #(.PULSES(NUM_PULSES)) u_train (
        .clk_sys(clk_sys),
        .srst(srst),
        .start(trainStart),
        .busy(trainBusy),
        .tap(tap)
    );

    assign lowCarry = &byteAddr_reg[BYTE_ADDR_LOW_W-1:0];

    // Start condition of the current phase's pulse train
    always_comb begin
        startCond = 1'b0;
        case (phase_reg)
            PH_CONNECT: startCond = serviceCall && permit_reg;
            PH_ADDRESS: startCond = functionStrobeLeadingResponse;
            PH_INTAKE: startCond = requestStrobe && !memPend_reg;
            // Byte waits for FIFO room so stalls reach the phase
            PH_XFER: startCond = fifoInReady;
            PH_FETCH1, PH_FETCH2, PH_LOAD: startCond = !memPend_reg;
            PH_CARRY: startCond = 1'b1;
            // strobe, stage two primed, no memory
            // Stage two stays primed (clear) from intake T1 until the
            // strobe drops, so waiting for it set would never start
            PH_TERM: startCond = requestStrobe && !ackTwo_reg
                && !memPend_reg;
            default: startCond = 1'b0;
        endcase
    end
    assign trainStart = startCond && !trainBusy;

    // --------------------------------------------------------
    // Phase latch
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_reg <= PH_CONNECT;
        end else if (tap[4]) begin
            case (phase_reg)
                PH_CONNECT: phase_reg <= PH_ADDRESS;
                PH_ADDRESS: phase_reg <= PH_INTAKE;
                PH_INTAKE: begin
                    if (orderFlag_reg || errorHalt_reg ||
                        !endService_reg) begin
                        phase_reg <= orderFlag_reg ? PH_TERM : PH_XFER;
                    end else begin
                        phase_reg <= PH_TERM;
                    end
                end
                PH_XFER: begin
                    if (zeroCount_reg && dataChainIn && !errorHalt_reg) begin
                        phase_reg <= PH_FETCH1;
                    end else if (!zeroCount_reg && branch_reg) begin
                        phase_reg <= PH_CARRY;
                    end else if (zeroCount_reg || endData_reg) begin
                        phase_reg <= PH_TERM;
                    end else begin
                        phase_reg <= PH_XFER;
                    end
                end
                PH_CARRY: phase_reg <= endData_reg ? PH_TERM : PH_XFER;
                PH_FETCH1: phase_reg <= PH_FETCH2;
                PH_FETCH2: phase_reg <= branch_reg ? PH_FETCH1 : PH_LOAD;
                PH_LOAD: phase_reg <= PH_TERM;
                PH_TERM: phase_reg <= PH_CONNECT;
                default: phase_reg <= PH_CONNECT;
            endcase
        end
    end

    // --------------------------------------------------------
    // Connection handshake
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            functionIndicator_reg <= 1'b0;
            fsPending_reg <= 1'b0;
        end else begin
            if (phase_reg == PH_CONNECT && tap[2] && serviceCall) begin
                functionIndicator_reg <= 1'b1;
            end else if (phase_reg == PH_INTAKE && tap[1]) begin
                functionIndicator_reg <= 1'b0;
            end
            if (phase_reg == PH_CONNECT && tap[4] &&
                functionIndicator_reg) begin
                fsPending_reg <= 1'b1;
            end else if (functionStrobeLeadingResponse) begin
                fsPending_reg <= 1'b0;
            end
        end
    end

    // New-operation permit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            permit_reg <= 1'b1;
        end else if (phase_reg == PH_INTAKE && tap[2]) begin
            permit_reg <= 1'b0;
        end else if (phase_reg == PH_TERM && tap[4]) begin
            permit_reg <= 1'b1;
        end
    end

    // --------------------------------------------------------
    // Subchannel select
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            subchannelAddr <= '0;
        end else if (phase_reg == PH_ADDRESS && tap[0]) begin
            subchannelAddr <= '0;
        end else if (phase_reg == PH_ADDRESS && tap[1] &&
                     functionIndicator_reg) begin
            subchannelAddr <= functionResponseLines;
        end
    end

    // --------------------------------------------------------
    // Cycle flags
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || (phase_reg == PH_ADDRESS && tap[1])) begin
            orderFlag_reg <= 1'b0;
            errorHalt_reg <= 1'b0;
            termOrder_reg <= 1'b0;
            zeroCount_reg <= 1'b0;
            boundary_reg <= 1'b0;
            endData_reg <= 1'b0;
            endService_reg <= 1'b0;
            branch_reg <= 1'b0;
            firstPass_reg <= !srst;
        end else begin
            if (phase_reg == PH_INTAKE && tap[1] && dataOrderLine &&
                !inputOutputLine) begin
                orderFlag_reg <= 1'b1;
            end
            if (phase_reg == PH_INTAKE && tap[0] && lowCarry) begin
                endData_reg <= 1'b1;
                endService_reg <= 1'b1;
                boundary_reg <= 1'b1;
            end else if (phase_reg == PH_INTAKE && tap[2] &&
                         orderFlag_reg) begin
                endService_reg <= 1'b0;
                termOrder_reg <= 1'b1;
            end
            if (phase_reg == PH_XFER && tap[2]) begin
                firstPass_reg <= 1'b0;
                branch_reg <= &byteAddr_reg[BYTE_ADDR_LOW_W-1:0];
                if (deviceEndData) begin
                    endData_reg <= 1'b1;
                end
                if (byteCount_reg == COUNT_BITS'(1)) begin
                    zeroCount_reg <= 1'b1;
                    termOrder_reg <= !dataChainIn;
                end
            end
            // Branch flag from the first command word's order bits
            if (phase_reg == PH_FETCH1 && tap[3]) begin
                branch_reg <= (memData[27:24] == 4'h8);
            end
            if (phase_reg == PH_TERM && tap[0] && errorHaltEnableIn &&
                incorrectLengthIn && !flagStatusIn[SIL_BIT]) begin
                errorHalt_reg <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------
    // Acknowledge stages
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ackOne_reg <= 1'b0;
            ackTwo_reg <= 1'b1;
        end else begin
            if ((phase_reg == PH_INTAKE || phase_reg == PH_TERM) &&
                tap[0]) begin
                ackOne_reg <= 1'b0;
            end else if ((phase_reg == PH_TERM || phase_reg == PH_XFER) &&
                         tap[3]) begin
                ackOne_reg <= 1'b1;
            end
            if (phase_reg == PH_INTAKE && tap[1]) begin
                ackTwo_reg <= 1'b0;
            end else if (ackOne_reg && !requestStrobe) begin
                ackTwo_reg <= 1'b1;
            end
        end
    end

    assign requestStrobeAck = ackOne_reg && !ackTwo_reg;

    // --------------------------------------------------------
    // Address, count and memory
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            byteAddr_reg <= '0;
            byteCount_reg <= '0;
            memPend_reg <= 1'b0;
            holding_reg <= WORD_RST;
            carryIn_reg <= 1'b1;
        end else begin
            if (phase_reg == PH_ADDRESS && tap[2]) begin
                byteAddr_reg <= byteAddrIn;
                byteCount_reg <= byteCountIn;
                carryIn_reg <= 1'b1;
            end
            if ((phase_reg == PH_INTAKE && tap[3] && !orderFlag_reg) ||
                ((phase_reg == PH_FETCH1 || phase_reg == PH_FETCH2) &&
                 tap[1])) begin
                memPend_reg <= 1'b1;
            end else if (memAck) begin
                memPend_reg <= 1'b0;
                holding_reg <= memData;
            end
            if (phase_reg == PH_XFER && tap[3]) begin
                byteCount_reg <= byteCount_reg - COUNT_BITS'(1);
                byteAddr_reg[BYTE_ADDR_LOW_W-1:0] <=
                    byteAddr_reg[BYTE_ADDR_LOW_W-1:0] + 1'b1;
            end
            if (phase_reg == PH_CARRY && tap[1]) begin
                byteAddr_reg[18:BYTE_ADDR_LOW_W] <=
                    byteAddr_reg[18:BYTE_ADDR_LOW_W] + 1'b1;
            end
            if (phase_reg == PH_LOAD && tap[2]) begin
                byteCount_reg <= memData[COUNT_BITS-1:0];
                byteAddr_reg <= holding_reg[18:0];
            end
            if (phase_reg == PH_TERM && tap[0]) begin
                holding_reg <= WORD_RST;
                carryIn_reg <= 1'b0;
            end
        end
    end

    assign memReq = memPend_reg;
    assign memAddr = byteAddr_reg;

    // --------------------------------------------------------
    // Byte stream through FIFO
    // --------------------------------------------------------
    // one byte per transfer phase
    assign pushByte = (phase_reg == PH_XFER) && tap[1];

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .inValid(pushByte),
        .inReady(fifoInReady),
        .inData(holding_reg[8*byteAddr_reg[1:0] +: 8]),
        .outValid(byteValid),
        .outReady(byteReady),
        .outData(byteData)
    );

    // --------------------------------------------------------
    // Termination
    // --------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            order_reg <= '0;
            work_reg <= FLAGS_RST;
            cycleDone <= 1'b0;
        end else begin
            cycleDone <= (phase_reg == PH_TERM) && tap[4];
            if (phase_reg == PH_TERM && tap[0] && termOrder_reg) begin
                order_reg <= '0;
            end else if (phase_reg == PH_TERM && tap[2] && termOrder_reg) begin
                order_reg <= statusByte;
            end
            if (phase_reg == PH_TERM && tap[1]) begin
                work_reg[STAT_HI:STAT_LO] <= flagStatusIn[STAT_HI:STAT_LO];
                if (errorHalt_reg) begin
                    work_reg[7:0] <= flagStatusIn[7:0];
                end else begin
                    work_reg[7:0] <= holding_reg[7:0];
                end
            end
        end
    end

    assign ackServiceCallIndicator = functionIndicator_reg;
    assign functionStrobe = fsPending_reg;
    assign endServiceOut = endService_reg;
    assign endDataOut = endData_reg;
    assign workingStatus = work_reg;
    assign errorReport = errorHalt_reg;
    assign terminalOrder = order_reg;

    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    sequence s_connT2;
        phase_reg == PH_CONNECT && tap[2] && serviceCall;
    endsequence

    property p_indicator_set;
        @(posedge clk_sys) disable iff (srst)
        s_connT2 |=> ackServiceCallIndicator;
    endproperty
    a_indicator_set: assert property (p_indicator_set)
        else $error("indicator not set at T2");

    // Once the strobe is withdrawn, stage two closes the acknowledge
    property p_ack_gate;
        @(posedge clk_sys) disable iff (srst)
        (ackOne_reg && !requestStrobe &&
            !(phase_reg == PH_INTAKE && tap[1])) |=> !requestStrobeAck;
    endproperty
    a_ack_gate: assert property (p_ack_gate)
        else $error("acknowledge outside stage window");

    property p_pulse_order;
        @(posedge clk_sys) disable iff (srst)
        tap[0] |=> tap[1] ##1 tap[2] ##1 tap[3] ##1 tap[4];
    endproperty
    a_pulse_order: assert property (p_pulse_order)
        else $error("pulse train out of order");

    property p_term_start;
        @(posedge clk_sys) disable iff (srst)
        (phase_reg == PH_TERM && $rose(tap[0])) |->
            $past(requestStrobe) && !$past(ackTwo_reg) &&
            !$past(memPend_reg);
    endproperty
    a_term_start: assert property (p_term_start)
        else $error("termination started without strobe");

    property p_addr_wait;
        @(posedge clk_sys) disable iff (srst)
        (phase_reg == PH_ADDRESS && tap[0]) |->
            $past(functionStrobeLeadingResponse);
    endproperty
    a_addr_wait: assert property (p_addr_wait)
        else $error("addressing started early");

    property p_intake_clear;
        @(posedge clk_sys) disable iff (srst)
        (phase_reg == PH_INTAKE && tap[1]) |=>
            !ackServiceCallIndicator && !ackTwo_reg;
    endproperty
    a_intake_clear: assert property (p_intake_clear)
        else $error("function register not cleared");

    property p_first_pass;
        @(posedge clk_sys) disable iff (srst)
        (phase_reg == PH_ADDRESS && tap[1]) |=>
            firstPass_reg && !zeroCount_reg && !termOrder_reg;
    endproperty
    a_first_pass: assert property (p_first_pass)
        else $error("addressing T1 clear missing");

    property p_status_copy;
        @(posedge clk_sys) disable iff (srst)
        (phase_reg == PH_TERM && tap[1]) |=>
            work_reg[STAT_HI:STAT_LO] ==
            $past(flagStatusIn[STAT_HI:STAT_LO]);
    endproperty
    a_status_copy: assert property (p_status_copy)
        else $error("status bits not copied");
endmodule

// File: bench/ctrl_model.sv
`timescale 1ns/1ps
// ----
// Device controller model
// ----
module ctrl_model (
    // Clock and bench control
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [7:0] addr,
    // Controller interface
    output logic serviceCall,
    input wire logic functionStrobe,
    output logic function_strobe_leading_response,
    output logic [7:0] respLines,
    output logic requestStrobe,
    input wire logic cycleDone
);
    initial {serviceCall, function_strobe_leading_response, requestStrobe, respLines} = '0;
    // Answers the strobe and arms on its fall
    always @(posedge clk_sys) begin
        if (go) begin
            serviceCall <= 1'b1;
        end
        function_strobe_leading_response <= functionStrobe;
        // address on response lines
        // Idle lines toggle so stale data never looks valid
        if (functionStrobe | function_strobe_leading_response | requestStrobe) begin
            respLines <= addr;
        end else begin
            respLines <= ~respLines;
        end
        if (function_strobe_leading_response && !functionStrobe) begin
            serviceCall <= 1'b0;
            requestStrobe <= 1'b1;
        end
        if (cycleDone) begin
            requestStrobe <= 1'b0;
        end
    end
endmodule

// File: bench/io_channel_service_cycle_sequencer_bench.sv
`timescale 1ns/1ps
// ----
// Sequencer bench
// ----
module io_channel_service_cycle_sequencer_bench;
    import svc_seq_pkg::*;
    logic clk_sys = 0, srst = 1, go = 0, data_order_line = 0, input_output_line = 0, error_halt_enable = 0;
    logic byteReady = 0, memAck = 0, function_strobe_leading_response, serviceCall, requestStrobe;
    logic functionStrobe, ackServiceCallIndicator, memReq, cycleDone;
    logic byteValid, errorReport;
    logic chain = 0, devEnd = 0, requestStrobeAck, endServiceOut, endDataOut;
    logic [18:0] baseAddr = 0, memAddr;
    logic [7:0] addr = 0, respLines, byteData, subchannelAddr, terminalOrder;
    logic [15:0] flags = 0, count = 0, workingStatus;
    logic [7:0] got[$];
    int miscompares = 0, tests_run = 0, cycles = 0, memReads = 0;
    initial forever #25 clk_sys = ~clk_sys;
    // Far side stalls every other cycle; memory answers promptly
    always @(posedge clk_sys) begin
        byteReady <= ~byteReady;
        memAck <= memReq && !memAck;
        if (byteValid && byteReady) got.push_back(byteData);
        // One acknowledge pulse per memory read
        if (memAck) begin
            memReads <= memReads + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    ctrl_model i_ctrl_model (.clk_sys, .go, .addr, .serviceCall,
        .functionStrobe, .function_strobe_leading_response, .respLines, .requestStrobe, .cycleDone);
    service_cycle_sequencer i_service_cycle_sequencer (.clk_sys, .srst,
        .serviceCall, .ackServiceCallIndicator, .functionStrobe,
        .functionStrobeLeadingResponse(function_strobe_leading_response), .functionResponseLines(respLines),
        .requestStrobe, .requestStrobeAck, .dataOrderLine(data_order_line),
        .inputOutputLine(input_output_line), .deviceEndData(devEnd), .statusByte(8'h5A),
        .endServiceOut, .endDataOut, .byteValid, .byteReady, .byteData,
        .memReq, .memAddr, .memAck, .memData(32'h1122_3344),
        .subchannelAddr, .byteAddrIn(baseAddr), .byteCountIn(count),
        .dataChainIn(chain), .errorHaltEnableIn(error_halt_enable), .incorrectLengthIn(error_halt_enable),
        .flagStatusIn(flags), .workingStatus, .errorReport, .terminalOrder,
        .cycleDone);
    task automatic chk(input logic [18:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // One whole service cycle, started by the controller's call
    // b: start byte address, c: chaining, x: device end data,
    // m: memory reads expected in the whole cycle
    task automatic cyc(input logic d, e, input logic [15:0] f, n,
                       input logic [7:0] a, input logic [18:0] b,
                       input logic c, x, input int m);
        logic ack_service_call_indicator;
        logic ack;
        int r0;
        ack_service_call_indicator = 0;
        ack = 0;
        r0 = memReads;
        got.delete();
        data_order_line <= d;
        input_output_line <= ~d;
        error_halt_enable <= e;
        flags <= f;
        count <= n;
        addr <= a;
        baseAddr <= b;
        chain <= c;
        devEnd <= x;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int k = 0; k < 400 && cycleDone !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
            if (ackServiceCallIndicator === 1'b1) ack_service_call_indicator = 1;
            if (requestStrobeAck === 1'b1) ack = 1;
        end
        chk(cycleDone, 1, "cycle not done");
        chk(ack_service_call_indicator, 1, "service call never acknowledged");
        chk(ack, 1, "request strobe never acknowledged");
        chk(ackServiceCallIndicator, 0, "indicator stuck");
        chk(subchannelAddr, a, "subchannel address");
        chk(workingStatus & 16'h7F00, f & 16'h7F00, "status copy");
        repeat (20) @(posedge clk_sys);
        chk(memReads - r0, m, "memory read count");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        cyc(1, 1, 16'h7F00, 16'h0001, 8'h05, 19'h0_0000, 0, 0, 0);
        chk(errorReport, 1, "length error missed");
        chk(terminalOrder, 8'h5A, "terminal order");
        $display("order-in with error done");
        cyc(1, 1, 16'h2A40, 16'h0001, 8'h1C, 19'h0_0007, 0, 0, 0);
        chk(errorReport, 0, "suppressed error reported");
        chk(endServiceOut, 0, "end service left set");
        chk(endDataOut, 1, "boundary end data missed");
        $display("order-in suppressed done");
        cyc(0, 0, 16'h5500, 16'h0002, 8'h03, 19'h0_0000, 0, 0, 1);
        chk(got.size(), 2, "byte count sent");
        chk(got[0], 8'h44, "first byte");
        chk(got[1], 8'h33, "second byte");
        chk(memAddr, 19'h0_0002, "byte address advance");
        $display("data-out done");
        cyc(0, 0, 16'h0000, 16'h0003, 8'h07, 19'h0_0006, 0, 0, 1);
        chk(got.size(), 3, "bytes across carry");
        chk(got[1], 8'h11, "last byte of word");
        chk(memAddr, 19'h0_0009, "carry into upper bits");
        $display("address carry done");
        cyc(0, 0, 16'h0000, 16'h0003, 8'h02, 19'h0_0000, 0, 1, 1);
        chk(got.size(), 1, "end data did not stop");
        chk(endDataOut, 1, "end data flag");
        $display("end data done");
        cyc(0, 0, 16'h0000, 16'h0001, 8'h04, 19'h0_0000, 1, 0, 3);
        chk(got.size(), 1, "chained byte count");
        $display("data chaining done");
        close_out();
    end
endmodule
